/* File: fbsel_ctrl.sv */
`timescale 1ns/100ps
module fbsel_ctrl (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // object access
  input  wire logic        od_req,
  input  wire logic        od_wr,
  input  wire logic [15:0] od_index,
  input  wire logic [7:0]  od_subindex,
  input  wire logic [31:0] od_wdata,
  output logic      [31:0] od_rdata,
  output logic             od_ack,
  output logic             od_err,
  // fieldbus side
  input  wire logic [31:0] fb_switchable,
  output logic      [31:0] fb_enabled,
  // program engine side
  input  wire logic        prg_loaded,
  input  wire logic        prg_fault,
  input  wire logic [31:0] prg_fault_code,
  output logic             prg_reload,
  output logic             prg_clear_vars,
  output logic             prg_execute
);

  // register file state
  logic [31:0] fb_ctrl_q, fb_ctrl_d;
  logic [31:0] fb_mask_q, fb_mask_d;
  logic [31:0] fb_en_q, fb_en_d;
  logic [31:0] prg_ctrl_q, prg_ctrl_d;
  logic [31:0] prg_errc_q, prg_errc_d;
  logic        prg_errf_q, prg_errf_d;
  logic [31:0] rdata_q, rdata_d;
  logic        ack_q, ack_d;
  logic        err_q, err_d;
  // program engine state
  fbsel_pkg::fbsel_prg_e ps_q, ps_d;
  logic        reload_q, reload_d;
  logic        clear_q, clear_d;
  logic        exec_q, exec_d;

  logic        wr_fb_ctrl;
  logic        wr_prg_ctrl;
  logic        start_edge;
  logic        hit;
  logic        writable;
  logic [31:0] rd_val;
  logic [31:0] prg_status;

  always_comb begin
    wr_fb_ctrl  = od_req && od_wr && od_index == fbsel_pkg::IDX_FB_CTRL
                  && od_subindex == fbsel_pkg::SUB_COUNT;
    wr_prg_ctrl = od_req && od_wr && od_index == fbsel_pkg::IDX_PRG_CTRL
                  && od_subindex == fbsel_pkg::SUB_COUNT;
    prg_status  = '0;
    prg_status[fbsel_pkg::PRG_RUN_BIT] = exec_q;
    prg_status[fbsel_pkg::PRG_ERR_BIT] = prg_errf_q;
  end

  // read mux and access check
  always_comb begin
    hit      = 1'b1;
    writable = 1'b0;
    rd_val   = '0;
    if (od_index == fbsel_pkg::IDX_FB_STATUS) begin
      case (od_subindex)
        fbsel_pkg::SUB_COUNT:   rd_val = {24'h000000, fbsel_pkg::STATUS_COUNT};
        fbsel_pkg::SUB_MASK:    rd_val = fb_mask_q;
        fbsel_pkg::SUB_ENABLED: rd_val = fb_en_q;
        default:                hit = 1'b0;
      endcase
    end else if (od_subindex != fbsel_pkg::SUB_COUNT) begin
      hit = 1'b0;
    end else begin
      case (od_index)
        fbsel_pkg::IDX_AVAIL:      rd_val = fbsel_pkg::AVAIL_PRESENT;
        fbsel_pkg::IDX_FB_CTRL: begin
          rd_val   = fb_ctrl_q;
          writable = 1'b1;
        end
        fbsel_pkg::IDX_PRG_CTRL: begin
          rd_val   = prg_ctrl_q;
          writable = 1'b1;
        end
        fbsel_pkg::IDX_PRG_STATUS: rd_val = prg_status;
        fbsel_pkg::IDX_PRG_ERRC:   rd_val = prg_errc_q;
        default:                   hit = 1'b0;
      endcase
    end
  end

  // answer one cycle after the request; writes to read-only entries refused
  always_comb begin
    ack_d   = od_req;
    err_d   = od_req && (!hit || (od_wr && !writable));
    rdata_d = (od_req && !od_wr && hit) ? rd_val : '0;
  end

  // fieldbus switching
  always_comb begin
    fb_ctrl_d = fb_ctrl_q;
    if (wr_fb_ctrl) begin
      fb_ctrl_d = od_wdata & fbsel_pkg::MAP_DEFINED;
    end
    // only present, defined bits can ever be switchable
    fb_mask_d = fb_switchable & fbsel_pkg::AVAIL_PRESENT & fbsel_pkg::MAP_DEFINED;
    // unswitchable bits hold, switchable bits follow the control word
    fb_en_d   = (fb_en_q & ~fb_mask_q) | (fb_ctrl_q & fb_mask_q);
  end

  assign start_edge = wr_prg_ctrl && od_wdata[fbsel_pkg::PRG_ON_BIT]
                      && !prg_ctrl_q[fbsel_pkg::PRG_ON_BIT];

  // user program engine
  always_comb begin
    prg_ctrl_d = wr_prg_ctrl ? od_wdata : prg_ctrl_q;
    prg_errc_d = prg_errc_q;
    prg_errf_d = prg_errf_q;
    ps_d       = ps_q;
    reload_d   = 1'b0;
    clear_d    = 1'b0;
    if (start_edge) begin
      // a fresh start forgets the old fault before loading
      ps_d       = fbsel_pkg::PS_LOAD;
      reload_d   = 1'b1;
      clear_d    = 1'b1;
      prg_errf_d = 1'b0;
      prg_errc_d = fbsel_pkg::PRG_ERRC_RST;
    end else if (!prg_ctrl_q[fbsel_pkg::PRG_ON_BIT]) begin
      if (ps_q != fbsel_pkg::PS_ERR) begin
        ps_d = fbsel_pkg::PS_STOP;
      end
    end else begin
      case (ps_q)
        fbsel_pkg::PS_LOAD: begin
          if (prg_fault) begin
            ps_d = fbsel_pkg::PS_ERR;
          end else if (prg_loaded) begin
            ps_d = fbsel_pkg::PS_RUN;
          end
        end
        fbsel_pkg::PS_RUN: begin
          if (prg_fault) begin
            ps_d = fbsel_pkg::PS_ERR;
          end
        end
        fbsel_pkg::PS_STOP: ps_d = fbsel_pkg::PS_STOP;
        fbsel_pkg::PS_ERR:  ps_d = fbsel_pkg::PS_ERR;
        default:            ps_d = fbsel_pkg::PS_STOP;
      endcase
      if (prg_fault && (ps_q == fbsel_pkg::PS_LOAD || ps_q == fbsel_pkg::PS_RUN)) begin
        prg_errf_d = 1'b1;
        prg_errc_d = prg_fault_code;
      end
    end
    exec_d = (ps_d == fbsel_pkg::PS_RUN);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fb_ctrl_q  <= fbsel_pkg::FB_CTRL_RST;
      fb_mask_q  <= fbsel_pkg::FB_MASK_RST;
      fb_en_q    <= fbsel_pkg::FB_ENABLED_RST;
      prg_ctrl_q <= fbsel_pkg::PRG_CTRL_RST;
      prg_errc_q <= fbsel_pkg::PRG_ERRC_RST;
      prg_errf_q <= 1'b0;
      rdata_q    <= '0;
      ack_q      <= 1'b0;
      err_q      <= 1'b0;
      ps_q       <= fbsel_pkg::PS_STOP;
      reload_q   <= 1'b0;
      clear_q    <= 1'b0;
      exec_q     <= 1'b0;
    end else begin
      fb_ctrl_q  <= fb_ctrl_d;
      fb_mask_q  <= fb_mask_d;
      fb_en_q    <= fb_en_d;
      prg_ctrl_q <= prg_ctrl_d;
      prg_errc_q <= prg_errc_d;
      prg_errf_q <= prg_errf_d;
      rdata_q    <= rdata_d;
      ack_q      <= ack_d;
      err_q      <= err_d;
      ps_q       <= ps_d;
      reload_q   <= reload_d;
      clear_q    <= clear_d;
      exec_q     <= exec_d;
    end
  end

  assign od_rdata       = rdata_q;
  assign od_ack         = ack_q;
  assign od_err         = err_q;
  assign fb_enabled     = fb_en_q;
  assign prg_reload     = reload_q;
  assign prg_clear_vars = clear_q;
  assign prg_execute    = exec_q;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_AVAIL_READ: assert property (
    od_req && !od_wr && od_index == fbsel_pkg::IDX_AVAIL && od_subindex == 8'h00
    |=> od_ack && od_rdata == fbsel_pkg::AVAIL_PRESENT)
    else $error("availability word read wrong");
  AST_COUNT_READ: assert property (
    od_req && !od_wr && od_index == fbsel_pkg::IDX_FB_STATUS && od_subindex == 8'h00
    |=> od_rdata == 32'h00000002 && !od_err)
    else $error("status count entry not 2");
  AST_RO_REFUSED: assert property (
    od_req && od_wr && od_index == fbsel_pkg::IDX_FB_STATUS
    |=> od_ack && od_err && od_rdata == 32'h00000000)
    else $error("write to read-only status accepted");
  AST_LOCKED_BITS: assert property (
    $past(fb_mask_q) == 32'h0 |-> $stable(fb_enabled))
    else $error("unswitchable interface changed");
  AST_ENABLE_FOLLOWS: assert property (
    wr_fb_ctrl ##1 $stable(fb_mask_q) ##1 $stable(fb_mask_q)
    |-> (fb_enabled & fb_mask_q) == ($past(fb_ctrl_q) & fb_mask_q))
    else $error("enabled word missed control write");
  AST_START_PULSES: assert property (
    start_edge |=> prg_reload && prg_clear_vars && !prg_execute ##1 !prg_reload)
    else $error("reload not issued on rising run bit");
  AST_STOP: assert property (
    !prg_ctrl_q[0] && !start_edge |=> !prg_execute)
    else $error("program runs with run bit clear");
  AST_RUN_AFTER_LOAD: assert property (
    ps_q == fbsel_pkg::PS_LOAD && prg_ctrl_q[0] && prg_loaded && !prg_fault && !start_edge
    |=> prg_execute && !prg_reload)
    else $error("running flag missing after load");
  AST_FAULT_FLAG: assert property (
    exec_q && prg_ctrl_q[0] && prg_fault && !start_edge
    |=> prg_errf_q && !prg_execute && prg_errc_q == $past(prg_fault_code))
    else $error("program fault not recorded");
endmodule

/* File: fbsel_ctrl_tb_top.sv */
`timescale 1ns/100ps
module fbsel_ctrl_tb_top;
  logic        clock;
  logic        rst_n;
  logic        od_req;
  logic        od_wr;
  logic [15:0] od_index;
  logic [7:0]  od_subindex;
  logic [31:0] od_wdata;
  logic [31:0] od_rdata;
  logic        od_ack;
  logic        od_err;
  logic [31:0] fb_switchable;
  logic [31:0] fb_enabled;
  logic        prg_loaded;
  logic        prg_fault;
  logic [31:0] prg_fault_code;
  logic        prg_reload;
  logic        prg_clear_vars;
  logic        prg_execute;
  int          err_count;
  int          comparisons;
  logic [31:0] rd_s;
  logic        er_s;
  logic [31:0] ctrl_m;
  logic [31:0] en_m;
  logic [31:0] mask_m;
  logic [31:0] sw;
  logic [31:0] wd;
  logic [31:0] code;

  fbsel_ctrl fbsel_ctrl_inst (.clock(clock), .rst_n(rst_n), .od_req(od_req), .od_wr(od_wr),
    .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata), .od_rdata(od_rdata),
    .od_ack(od_ack), .od_err(od_err), .fb_switchable(fb_switchable), .fb_enabled(fb_enabled),
    .prg_loaded(prg_loaded), .prg_fault(prg_fault), .prg_fault_code(prg_fault_code),
    .prg_reload(prg_reload), .prg_clear_vars(prg_clear_vars), .prg_execute(prg_execute));

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // one access; answer sampled once its registered pulse has settled
  task automatic acc(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd_i);
    @(posedge clock);
    od_req      <= 1'b1;
    od_wr       <= wr;
    od_index    <= idx;
    od_subindex <= sub;
    od_wdata    <= wd_i;
    @(posedge clock);
    od_req <= 1'b0;
    #1;
    chk({31'h0, od_ack}, 32'h1, "ack one cycle after request");
    rd_s = od_rdata;
    er_s = od_err;
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] exp,
                        input logic bad);
    acc(1'b0, idx, sub, 32'h0);
    chk({31'h0, er_s}, {31'h0, bad}, "read refusal");
    chk(rd_s, exp, "read data");
  endtask

  task automatic wr_chk(input logic [15:0] idx, input logic [7:0] sub, input logic [31:0] d,
                        input logic bad);
    acc(1'b1, idx, sub, d);
    chk({31'h0, er_s}, {31'h0, bad}, "write refusal");
  endtask

  // rising edge of the run bit, then the engine reports its load done
  task automatic start_prg();
    acc(1'b1, 16'h2300, 8'h00, 32'h1);
    chk({29'h0, prg_reload, prg_clear_vars, prg_execute}, 32'h6, "reload before run");
    @(posedge clock);
    prg_loaded <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      #1;
      // software side waits a bounded time for the running indication
      if (prg_execute === 1'b1) break;
    end
    chk({31'h0, prg_execute}, 32'h1, "program running");
    @(posedge clock);
    prg_loaded <= 1'b0;
  endtask

  // run needs under 300 cycles; a hang is cut off well past that, at 20000 cycles
  initial begin
    #(25 * 20000);
    err_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h01af6317));
    err_count = 0;
    comparisons = 0;
    rst_n = 1'b0;
    {od_req, od_wr, prg_loaded, prg_fault} = 4'h0;
    od_index = 16'h0;
    od_subindex = 8'h0;
    od_wdata = 32'h0;
    prg_fault_code = 32'h0;
    sw = $urandom;
    fb_switchable = sw;
    repeat (16) @(posedge clock);
    chk(fb_enabled, 32'h00040010, "enabled set in reset");
    rst_n <= 1'b1;
    ctrl_m = 32'h00040010;
    en_m   = 32'h00040010;
    mask_m = sw & 32'h00040010;
    rd_chk(16'h2101, 8'h00, 32'h00040010, 1'b0);
    rd_chk(16'h2102, 8'h00, 32'h00040010, 1'b0);
    rd_chk(16'h2103, 8'h00, 32'h00000002, 1'b0);
    rd_chk(16'h2103, 8'h01, mask_m, 1'b0);
    rd_chk(16'h2103, 8'h02, 32'h00040010, 1'b0);
    rd_chk(16'h2300, 8'h00, 32'h0, 1'b0);
    rd_chk(16'h2301, 8'h00, 32'h0, 1'b0);
    rd_chk(16'h2103, 8'h03, 32'h0, 1'b1);
    wr_chk(16'h2101, 8'h00, 32'hffffffff, 1'b1);
    wr_chk(16'h2103, 8'h00, 32'h7, 1'b1);
    wr_chk(16'h2103, 8'h01, 32'hffffffff, 1'b1);
    wr_chk(16'h2103, 8'h02, 32'h0, 1'b1);
    wr_chk(16'h2301, 8'h00, 32'h5, 1'b1);
    rd_chk(16'h2101, 8'h00, 32'h00040010, 1'b0);
    rd_chk(16'h2103, 8'h02, en_m, 1'b0);
    for (int i = 0; i < 16; i++) begin
      sw = $urandom;
      wd = $urandom;
      @(posedge clock);
      fb_switchable <= sw;
      mask_m = sw & 32'h00040010;
      wr_chk(16'h2102, 8'h00, wd, 1'b0);
      ctrl_m = wd & 32'h0007007f;
      en_m = (en_m & ~mask_m) | (ctrl_m & mask_m);
      @(posedge clock);
      #1;
      chk(fb_enabled, en_m, "active set after write");
      rd_chk(16'h2102, 8'h00, ctrl_m, 1'b0);
      rd_chk(16'h2103, 8'h01, mask_m, 1'b0);
      rd_chk(16'h2103, 8'h02, en_m, 1'b0);
    end
    start_prg();
    rd_chk(16'h2301, 8'h00, 32'h1, 1'b0);
    acc(1'b1, 16'h2300, 8'h00, 32'h1);
    chk({31'h0, prg_reload}, 32'h0, "no reload without rising edge");
    acc(1'b1, 16'h2300, 8'h00, 32'h0);
    repeat (2) @(posedge clock);
    #1;
    chk({31'h0, prg_execute}, 32'h0, "program stopped");
    rd_chk(16'h2301, 8'h00, 32'h0, 1'b0);
    start_prg();
    code = $urandom;
    @(posedge clock);
    prg_fault      <= 1'b1;
    prg_fault_code <= code;
    @(posedge clock);
    prg_fault <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk({31'h0, prg_execute}, 32'h0, "halted on fault");
    rd_chk(16'h2301, 8'h00, 32'h4, 1'b0);
    rd_chk(16'h2302, 8'h00, code, 1'b0);
    acc(1'b1, 16'h2300, 8'h00, 32'h0);
    start_prg();
    rd_chk(16'h2301, 8'h00, 32'h1, 1'b0);
    // fault while still loading must end in the error state, never run
    acc(1'b1, 16'h2300, 8'h00, 32'h0);
    acc(1'b1, 16'h2300, 8'h00, 32'h1);
    code = $urandom;
    @(posedge clock);
    prg_fault      <= 1'b1;
    prg_fault_code <= code;
    @(posedge clock);
    prg_fault  <= 1'b0;
    prg_loaded <= 1'b1;
    repeat (2) @(posedge clock);
    prg_loaded <= 1'b0;
    #1;
    chk({31'h0, prg_execute}, 32'h0, "load fault keeps program stopped");
    rd_chk(16'h2301, 8'h00, 32'h4, 1'b0);
    rd_chk(16'h2302, 8'h00, code, 1'b0);
    give_verdict();
  end
endmodule

/* File: fbsel_pkg.sv */
package fbsel_pkg;
  // object dictionary indices
  localparam logic [15:0] IDX_AVAIL      = 16'h2101;
  localparam logic [15:0] IDX_FB_CTRL    = 16'h2102;
  localparam logic [15:0] IDX_FB_STATUS  = 16'h2103;
  localparam logic [15:0] IDX_PRG_CTRL   = 16'h2300;
  localparam logic [15:0] IDX_PRG_STATUS = 16'h2301;
  localparam logic [15:0] IDX_PRG_ERRC   = 16'h2302;
  // subindices
  localparam logic [7:0]  SUB_COUNT      = 8'h00;
  localparam logic [7:0]  SUB_MASK       = 8'h01;
  localparam logic [7:0]  SUB_ENABLED    = 8'h02;
  localparam logic [7:0]  STATUS_COUNT   = 8'h02;
  // interface bit positions
  localparam int          BIT_USB        = 0;
  localparam int          BIT_RS485      = 1;
  localparam int          BIT_RS232      = 2;
  localparam int          BIT_CANOPEN    = 3;
  localparam int          BIT_ETHERNET   = 4;
  localparam int          BIT_RT_ETH     = 5;
  localparam int          BIT_SPI        = 6;
  localparam int          BIT_MB_RTU     = 16;
  localparam int          BIT_MB_TCP     = 17;
  localparam int          BIT_IND_IP     = 18;
  // defined bits of the map, all others unused
  localparam logic [31:0] MAP_DEFINED    = 32'h0007007f;
  // interfaces and protocols built into this device
  localparam logic [31:0] AVAIL_PRESENT  = 32'h00040010;
  // reset values
  localparam logic [31:0] FB_CTRL_RST    = 32'h00040010;
  localparam logic [31:0] FB_MASK_RST    = 32'h00000000;
  localparam logic [31:0] FB_ENABLED_RST = 32'h00040010;
  localparam logic [31:0] PRG_CTRL_RST   = 32'h00000000;
  localparam logic [31:0] PRG_ERRC_RST   = 32'h00000000;
  // program control and status fields
  localparam int          PRG_ON_BIT     = 0;
  localparam int          PRG_RUN_BIT    = 0;
  localparam int          PRG_ERR_BIT    = 2;
  // program engine states
  typedef enum logic [3:0] {
    PS_STOP = 4'h1,
    PS_LOAD = 4'h2,
    PS_RUN  = 4'h4,
    PS_ERR  = 4'h8
  } fbsel_prg_e;
endpackage
